// [hdl/hdc_regs.vh]
// register offsets, field positions, reset values and scaling constants for the config bank
`ifndef HDC_REGS_VH
`define HDC_REGS_VH

// ****************************************************************
// register offsets (byte addresses on the serial register port)
// ****************************************************************
`define HDC_OFS_CONV_HI      8'h0f
`define HDC_OFS_CONV_LO      8'h10
`define HDC_OFS_IMP_HI       8'h11
`define HDC_OFS_IMP_LO       8'h12
`define HDC_OFS_FEATURE      8'h13
`define HDC_OFS_MEM_BRAKE    8'h14
`define HDC_OFS_HEADROOM     8'h15
`define HDC_OFS_CAL_UPD      8'h16
`define HDC_OFS_LIMITS       8'h17
`define HDC_OFS_TRK_KP_HI    8'h1c

// ****************************************************************
// reset values (unassigned bits are zero)
// ****************************************************************
`define HDC_RST_CONV_HI      8'h01
`define HDC_RST_CONV_LO      8'h0d
`define HDC_RST_FEATURE      8'h1e
`define HDC_RST_MEM_BRAKE    8'h01
`define HDC_RST_HEADROOM     8'h03
`define HDC_RST_CAL_UPD      8'h40
`define HDC_RST_LIMITS       8'h81
`define HDC_RST_TRK_KP_HI    8'h0e

// ****************************************************************
// writable-bit masks per register
// ****************************************************************
`define HDC_MSK_FEATURE      8'hbf
`define HDC_MSK_MEM_BRAKE    8'h1f
`define HDC_MSK_HEADROOM     8'h0f
`define HDC_MSK_CAL_UPD      8'hc0

// ****************************************************************
// field positions
// ****************************************************************
`define HDC_BIT_AUTO_CLEAR   7
`define HDC_BIT_ACT_KIND     5
`define HDC_BIT_LOOP_EN      4
`define HDC_BIT_TRACK_EN     3
`define HDC_BIT_ACCEL_EN     2
`define HDC_BIT_BRAKE_EN     1
`define HDC_BIT_AMP_EN       0
`define HDC_BIT_MEM_SIGNED   4
`define HDC_BIT_CONV_FREEZE  7
`define HDC_BIT_PLAY_CAL_DIS 6

// ****************************************************************
// scaling: headroom step 187.5 mV held in tenths of mV
// ****************************************************************
`define HDC_HEADROOM_STEP    16'h0753
// brake step: 6.66 percent, as 6.66/100 * 256 ~ 17 per code in 1/256 of full scale
`define HDC_BRAKE_STEP       8'h11

`endif

// [hdl/hdc_field_reg.v]
// one byte-wide writable configuration register with masked bits
`timescale 1ns/1ps
`default_nettype none

module hdc_field_reg #(
	parameter [7:0] RESET_VAL = 8'h00,   // value after reset
	parameter [7:0] WR_MASK   = 8'hff    // bits that exist
) (
	input  wire       core_clk,          // system clock
	input  wire       rst,               // synchronous reset
	input  wire       wr_en,             // write strobe for this register
	input  wire [7:0] wr_data,           // write data
	output reg  [7:0] value_q            // stored value
);

	// unassigned bits never leave zero, so readback needs no extra masking
	always @(posedge core_clk) begin
		if (rst) begin
			value_q <= RESET_VAL & WR_MASK;
		end else if (wr_en) begin
			value_q <= wr_data & WR_MASK;
		end
	end

endmodule // hdc_field_reg

`default_nettype wire

// [hdl/hdc_config_bank.v]
// configuration and calibration register bank of the haptic drive
// Functional notes
// - 16-bit conversion factor in two bytes
// - impedance readback is read-only, 8+2 bits
// - auto clear bit self-clears fault flags
// - actuator kind: 0 linear, 1 rotating mass
// - loop computation enable selects standard operation
// - tracking enable ignored for rotating mass
// - active acceleration enable, resets enabled
// - rapid stop enable, resets enabled
// - amplitude loop enable, resets disabled
// - memory samples signed or unsigned per bit
// - pwm full brake below code threshold
// - clamp drive to supply minus headroom
// - freeze stops automatic conversion updates
// - playback calibration disable blocks updates while a playback is running
// - frequency locked below four times limit
// - back-emf fault below selected threshold
// - tracking gain upper byte register 0x1c
`timescale 1ns/1ps
`default_nettype none
`include "hdc_regs.vh"

module hdc_config_bank (
	input  wire        core_clk,               // 100 MHz system clock
	input  wire        rst,                    // synchronous reset, active high
	// ****************************************************************
	// register port from the serial slave
	// ****************************************************************
	input  wire        reg_wr,                 // one-cycle write strobe
	input  wire        reg_rd,                 // one-cycle read strobe
	input  wire [7:0]  reg_addr,               // register byte offset
	input  wire [7:0]  reg_wdata,              // write data
	output reg  [7:0]  reg_rdata_q,            // read data, valid cycle after reg_rd
	// ****************************************************************
	// calibration engine side
	// ****************************************************************
	input  wire        cal_upd_valid,          // engine offers a new conversion factor
	input  wire [15:0] cal_upd_factor,         // offered factor
	input  wire        playback_active,        // a playback is running
	input  wire        imp_valid,              // new impedance measurement
	input  wire [9:0]  imp_measured,           // {high 8, low 2} in 62.5 mohm steps
	// ****************************************************************
	// datapath observations
	// ****************************************************************
	input  wire [15:0] target_mv10,            // target drive, tenths of mV
	input  wire [15:0] supply_mv10,            // supply, tenths of mV
	input  wire [7:0]  pwm_level,              // pwm input duty, 1/256 of full scale
	input  wire [7:0]  track_error,            // frequency tracking error magnitude
	input  wire [1:0]  bemf_level_code,        // sensed back-emf vs 4.9/27.9/49.9 mV marks
	input  wire        fault_clear,            // host clears latched faults
	// ****************************************************************
	// configuration outputs
	// ****************************************************************
	output reg  [15:0] drive_conversion_factor_q,
	output reg         drive_erm_q,            // 1 = rotating mass target
	output reg         loop_computation_enable_q,
	output reg         tracking_active_q,      // tracking enabled and linear actuator
	output reg         accel_enable_q,
	output reg         rapid_stop_enable_q,
	output reg         amplitude_loop_enable_q,
	output reg         mem_signed_q,           // 1 = signed samples
	output reg         pwm_full_brake_q,       // apply full brake
	output reg  [15:0] drive_limited_mv10_q,   // clamped target
	output reg         drive_clamped_event_q,  // latched clamp fault
	output reg         freq_locked_q,          // gain scaling allowed
	output reg         backemf_fault_q,        // latched back-emf fault
	output reg  [7:0]  tracking_prop_gain_upper_q
);

	// ****************************************************************
	// address decode
	// ****************************************************************
	wire wr_feature = reg_wr && (reg_addr == `HDC_OFS_FEATURE);   // feature write
	wire wr_mem     = reg_wr && (reg_addr == `HDC_OFS_MEM_BRAKE); // memory/brake write
	wire wr_head    = reg_wr && (reg_addr == `HDC_OFS_HEADROOM);  // headroom write
	wire wr_cal     = reg_wr && (reg_addr == `HDC_OFS_CAL_UPD);   // calibration cfg write
	wire wr_lim     = reg_wr && (reg_addr == `HDC_OFS_LIMITS);    // limits write
	wire wr_kp      = reg_wr && (reg_addr == `HDC_OFS_TRK_KP_HI); // gain write

	wire [7:0] feature_q;     // feature config
	wire [7:0] mem_brake_q;   // memory/brake config
	wire [7:0] headroom_q;    // headroom config
	wire [7:0] cal_upd_q;     // calibration update config
	wire [7:0] limits_q;      // lock and fault limits
	wire [7:0] kp_hi_q;       // tracking gain upper byte

	// ****************************************************************
	// plain configuration registers
	// ****************************************************************
	hdc_field_reg #(.RESET_VAL(`HDC_RST_FEATURE), .WR_MASK(`HDC_MSK_FEATURE)) u_feature (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_feature),
		.wr_data  (reg_wdata),
		.value_q  (feature_q)
	);
	hdc_field_reg #(.RESET_VAL(`HDC_RST_MEM_BRAKE), .WR_MASK(`HDC_MSK_MEM_BRAKE)) u_mem (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_mem),
		.wr_data  (reg_wdata),
		.value_q  (mem_brake_q)
	);
	hdc_field_reg #(.RESET_VAL(`HDC_RST_HEADROOM), .WR_MASK(`HDC_MSK_HEADROOM)) u_head (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_head),
		.wr_data  (reg_wdata),
		.value_q  (headroom_q)
	);
	hdc_field_reg #(.RESET_VAL(`HDC_RST_CAL_UPD), .WR_MASK(`HDC_MSK_CAL_UPD)) u_cal (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_cal),
		.wr_data  (reg_wdata),
		.value_q  (cal_upd_q)
	);
	hdc_field_reg #(.RESET_VAL(`HDC_RST_LIMITS), .WR_MASK(8'hff)) u_lim (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_lim),
		.wr_data  (reg_wdata),
		.value_q  (limits_q)
	);
	hdc_field_reg #(.RESET_VAL(`HDC_RST_TRK_KP_HI), .WR_MASK(8'hff)) u_kp (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_kp),
		.wr_data  (reg_wdata),
		.value_q  (kp_hi_q)
	);

	// ****************************************************************
	// conversion factor: host writes, engine updates unless frozen or blocked during playback
	// ****************************************************************
	reg  [7:0] conv_hi_q;   // factor high byte
	reg  [7:0] conv_lo_q;   // factor low byte
	// auto update is blocked by freeze, or by the playback disable while playing
	wire cal_allow = !cal_upd_q[`HDC_BIT_CONV_FREEZE] &&
	                 !(cal_upd_q[`HDC_BIT_PLAY_CAL_DIS] && playback_active);

	// host write takes priority over an engine update in the same cycle
	always @(posedge core_clk) begin
		if (rst) begin
			conv_hi_q <= `HDC_RST_CONV_HI;
			conv_lo_q <= `HDC_RST_CONV_LO;
		end else begin
			if (cal_upd_valid && cal_allow) begin
				conv_hi_q <= cal_upd_factor[15:8];
				conv_lo_q <= cal_upd_factor[7:0];
			end
			if (reg_wr && reg_addr == `HDC_OFS_CONV_HI) begin
				conv_hi_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == `HDC_OFS_CONV_LO) begin
				conv_lo_q <= reg_wdata;
			end
		end
	end

	// ****************************************************************
	// impedance readback, hardware written only
	// ****************************************************************
	reg  [9:0] imp_q;   // {high, low} impedance code

	// writes from the host are not decoded here, so it stays read-only
	always @(posedge core_clk) begin
		if (rst) begin
			imp_q <= 10'h000;
		end else if (imp_valid) begin
			imp_q <= imp_measured;
		end
	end

	// ****************************************************************
	// derived thresholds
	// ****************************************************************
	wire [15:0] headroom_mv10 = {12'h000, headroom_q[3:0]} * `HDC_HEADROOM_STEP;
	wire [15:0] drive_ceiling = (supply_mv10 > headroom_mv10) ?
	                            (supply_mv10 - headroom_mv10) : 16'h0000;
	wire        over_ceiling  = target_mv10 > drive_ceiling;
	wire [11:0] brake_thr     = {8'h00, mem_brake_q[3:0]} * {4'h0, `HDC_BRAKE_STEP};
	wire        brake_now     = (mem_brake_q[3:0] != 4'h0) &&
	                            ({4'h0, pwm_level} < brake_thr);
	wire        lock_now      = track_error < {limits_q[7:2], 2'b00};
	// bemf code counts how many marks the signal clears; below selected mark is a fault
	wire        bemf_low      = (limits_q[1:0] != 2'b00) &&
	                            (bemf_level_code < limits_q[1:0]);
	wire        auto_clear    = feature_q[`HDC_BIT_AUTO_CLEAR];

	// ****************************************************************
	// registered outputs and fault flags
	// ****************************************************************
	// a fault source still present wins over a clear in the same cycle
	always @(posedge core_clk) begin
		if (rst) begin
			drive_conversion_factor_q  <= {`HDC_RST_CONV_HI, `HDC_RST_CONV_LO};
			drive_erm_q                <= 1'b0;
			loop_computation_enable_q  <= 1'b1;
			tracking_active_q          <= 1'b1;
			accel_enable_q             <= 1'b1;
			rapid_stop_enable_q        <= 1'b1;
			amplitude_loop_enable_q    <= 1'b0;
			mem_signed_q               <= 1'b0;
			pwm_full_brake_q           <= 1'b0;
			drive_limited_mv10_q       <= 16'h0000;
			drive_clamped_event_q      <= 1'b0;
			freq_locked_q              <= 1'b0;
			backemf_fault_q            <= 1'b0;
			tracking_prop_gain_upper_q <= `HDC_RST_TRK_KP_HI;
		end else begin
			drive_conversion_factor_q  <= {conv_hi_q, conv_lo_q};
			drive_erm_q                <= feature_q[`HDC_BIT_ACT_KIND];
			loop_computation_enable_q  <= feature_q[`HDC_BIT_LOOP_EN];
			tracking_active_q          <= feature_q[`HDC_BIT_TRACK_EN] &&
			                              !feature_q[`HDC_BIT_ACT_KIND];
			accel_enable_q             <= feature_q[`HDC_BIT_ACCEL_EN];
			rapid_stop_enable_q        <= feature_q[`HDC_BIT_BRAKE_EN];
			amplitude_loop_enable_q    <= feature_q[`HDC_BIT_AMP_EN];
			mem_signed_q               <= mem_brake_q[`HDC_BIT_MEM_SIGNED];
			pwm_full_brake_q           <= brake_now;
			drive_limited_mv10_q       <= over_ceiling ? drive_ceiling : target_mv10;
			freq_locked_q              <= lock_now;
			tracking_prop_gain_upper_q <= kp_hi_q;
			// latched faults: auto clear drops them once the cause is gone
			if (over_ceiling) begin
				drive_clamped_event_q <= 1'b1;
			end else if (auto_clear || fault_clear) begin
				drive_clamped_event_q <= 1'b0;
			end
			if (bemf_low) begin
				backemf_fault_q <= 1'b1;
			end else if (auto_clear || fault_clear) begin
				backemf_fault_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// read mux, one cycle latency; unmapped reads return zero
	// ****************************************************************
	always @(posedge core_clk) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`HDC_OFS_CONV_HI:   reg_rdata_q <= conv_hi_q;
				`HDC_OFS_CONV_LO:   reg_rdata_q <= conv_lo_q;
				`HDC_OFS_IMP_HI:    reg_rdata_q <= imp_q[9:2];
				`HDC_OFS_IMP_LO:    reg_rdata_q <= {6'h00, imp_q[1:0]};
				`HDC_OFS_FEATURE:   reg_rdata_q <= feature_q;
				`HDC_OFS_MEM_BRAKE: reg_rdata_q <= mem_brake_q;
				`HDC_OFS_HEADROOM:  reg_rdata_q <= headroom_q;
				`HDC_OFS_CAL_UPD:   reg_rdata_q <= cal_upd_q;
				`HDC_OFS_LIMITS:    reg_rdata_q <= limits_q;
				`HDC_OFS_TRK_KP_HI: reg_rdata_q <= kp_hi_q;
				default:            reg_rdata_q <= 8'h00;
			endcase
		end
	end

endmodule // hdc_config_bank

`default_nettype wire

// [test/hdc_config_bank_asserts.sv]
// concurrent checks on the configuration bank ports
`timescale 1ns/1ps
`default_nettype none

module hdc_config_bank_asserts (
	input wire        core_clk,
	input wire        rst,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire [7:0]  reg_rdata_q,
	input wire [15:0] target_mv10,
	input wire [15:0] supply_mv10,
	input wire [15:0] drive_conversion_factor_q,
	input wire        drive_erm_q,
	input wire        loop_computation_enable_q,
	input wire        tracking_active_q,
	input wire        accel_enable_q,
	input wire        rapid_stop_enable_q,
	input wire        amplitude_loop_enable_q,
	input wire [15:0] drive_limited_mv10_q,
	input wire        drive_clamped_event_q,
	input wire [7:0]  tracking_prop_gain_upper_q
);
	// offsets that hold a register; all others read zero
	wire mapped = (reg_addr >= 8'h0f && reg_addr <= 8'h17) || reg_addr == 8'h1c;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// ****************************************************************
	// register port steps
	// ****************************************************************
	sequence s_wr(a);
		reg_wr && reg_addr == a;
	endsequence
	sequence s_rd(a);
		reg_rd && reg_addr == a;
	endsequence
	// a write lands in the register, then in the output flop
	a_feature_write: assert property (s_wr(8'h13) |-> ##2
		{drive_erm_q, loop_computation_enable_q, accel_enable_q, rapid_stop_enable_q,
		amplitude_loop_enable_q} == $past({reg_wdata[5:4], reg_wdata[2:0]}, 2))
		else $error("feature outputs do not follow write");
	a_track_gate: assert property (tracking_active_q |-> !drive_erm_q)
		else $error("tracking active with rotating mass");
	a_gain_write: assert property (s_wr(8'h1c) |-> ##2
		tracking_prop_gain_upper_q == $past(reg_wdata, 2))
		else $error("gain output does not follow write");
	a_gain_read: assert property (s_rd(8'h1c) |=> reg_rdata_q == tracking_prop_gain_upper_q)
		else $error("gain readback differs from output");
	a_factor_write: assert property (s_wr(8'h0f) |-> ##2
		drive_conversion_factor_q[15:8] == $past(reg_wdata, 2))
		else $error("factor high byte does not follow write");
	a_factor_read: assert property (s_rd(8'h10) |=> reg_rdata_q == drive_conversion_factor_q[7:0])
		else $error("factor low readback differs");
	a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data moved without a read");
	// the clamp never raises the target nor passes the supply
	a_clamp_bound: assert property (drive_limited_mv10_q <= $past(target_mv10) &&
		drive_limited_mv10_q <= $past(supply_mv10))
		else $error("limited drive above target or supply");
	a_clamp_event: assert property (!$past(rst) && $past(target_mv10) > drive_limited_mv10_q
		|-> drive_clamped_event_q)
		else $error("clamp without event");
endmodule // hdc_config_bank_asserts

bind hdc_config_bank hdc_config_bank_asserts u_chk (
	.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
	.target_mv10(target_mv10), .supply_mv10(supply_mv10),
	.drive_conversion_factor_q(drive_conversion_factor_q), .drive_erm_q(drive_erm_q),
	.loop_computation_enable_q(loop_computation_enable_q),
	.tracking_active_q(tracking_active_q), .accel_enable_q(accel_enable_q),
	.rapid_stop_enable_q(rapid_stop_enable_q),
	.amplitude_loop_enable_q(amplitude_loop_enable_q),
	.drive_limited_mv10_q(drive_limited_mv10_q),
	.drive_clamped_event_q(drive_clamped_event_q),
	.tracking_prop_gain_upper_q(tracking_prop_gain_upper_q));
`default_nettype wire

// [test/hdc_host_model.sv]
// host model: byte writes and reads on the raw register port
`timescale 1ns/1ps
`default_nettype none

module hdc_host_model (
	input  wire       core_clk,
	input  wire [7:0] reg_rdata_q,
	output reg        reg_wr,
	output reg        reg_rd,
	output reg  [7:0] reg_addr,
	output reg  [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// one-cycle strobe; released lines show the inverse so stale values never pass
	task wr(input [7:0] a, input [7:0] v);
		begin
			@(posedge core_clk) #1;
			reg_addr = a;
			reg_wdata = v;
			reg_wr = 1'b1;
			@(posedge core_clk) #1;
			reg_wr = 1'b0;
			reg_addr = ~a;
			reg_wdata = ~v;
		end
	endtask
	// read data is taken one edge after the strobe edge; it holds until the next read
	// the task returns just after that edge, so callers never drive on the edge itself
	task rd(input [7:0] a, output [7:0] v);
		begin
			@(posedge core_clk) #1;
			reg_addr = a;
			reg_rd = 1'b1;
			@(posedge core_clk) #1;
			reg_rd = 1'b0;
			reg_addr = ~a;
			@(posedge core_clk);
			v = reg_rdata_q;
			#1;
		end
	endtask
endmodule // hdc_host_model
`default_nettype wire

// [test/hdc_config_bank_tb.sv]
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none

module hdc_config_bank_tb;
	reg         core_clk, rst, cal_upd_valid, playback_active, imp_valid, fault_clear;
	reg  [15:0] cal_upd_factor, target_mv10, supply_mv10, ef;
	reg  [9:0]  imp_measured;
	reg  [7:0]  pwm_level, track_error, d, a, v, v13, v14, vf, vl, vk;
	reg  [1:0]  bemf_level_code;
	reg  [31:0] r, rq;
	wire        reg_wr, reg_rd, erm_q, loop_q, trk_q, acc_q, rs_q, amp_q;
	wire        sgn_q, brk_q, clmp_q, lck_q, bf_q;
	wire [7:0]  reg_addr, reg_wdata, reg_rdata_q, kp_q;
	wire [15:0] fac_q, lim_q;
	integer     n_mismatch = 0, total_checks = 0, seed = 61695, i, k;
	// offsets, reset values and writable masks, eight bits per entry
	reg [103:0] ofs_t = 104'h0f10111213141516171c181bff;
	reg [103:0] rst_t = 104'h010d00001e010340810e000000;
	reg [103:0] msk_t = 104'hffff0000bf1f0fc0ffff000000;

	hdc_config_bank uut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
		.cal_upd_valid(cal_upd_valid), .cal_upd_factor(cal_upd_factor),
		.playback_active(playback_active), .imp_valid(imp_valid), .imp_measured(imp_measured),
		.target_mv10(target_mv10), .supply_mv10(supply_mv10), .pwm_level(pwm_level),
		.track_error(track_error), .bemf_level_code(bemf_level_code), .fault_clear(fault_clear),
		.drive_conversion_factor_q(fac_q), .drive_erm_q(erm_q), .loop_computation_enable_q(loop_q),
		.tracking_active_q(trk_q), .accel_enable_q(acc_q), .rapid_stop_enable_q(rs_q),
		.amplitude_loop_enable_q(amp_q), .mem_signed_q(sgn_q), .pwm_full_brake_q(brk_q),
		.drive_limited_mv10_q(lim_q), .drive_clamped_event_q(clmp_q), .freq_locked_q(lck_q),
		.backemf_fault_q(bf_q), .tracking_prop_gain_upper_q(kp_q));
	hdc_host_model host (.core_clk(core_clk), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

	// factor the host derives from impedance (mohm) and rated current (mA)
	function [15:0] f_fac(input integer z, input integer ma);
		f_fac = z * ((ma * 10 - 286) / 72 + 4) * 10 / 16104;
	endfunction
	// {event, limited drive}: ceiling is supply less code steps, floored at zero
	function [16:0] f_lim(input integer t, input integer s, input integer c);
		integer ce;
		begin
			ce = s - c * 1875;
			if (ce < 0) ce = 0;
			f_lim = (t > ce) ? {1'b1, ce[15:0]} : {1'b0, t[15:0]};
		end
	endfunction
	task chk(input [23:0] g, input [23:0] e);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task rdc(input [7:0] ad, input [7:0] e);
		begin
			host.rd(ad, d);
			chk({8'h00, d}, {8'h00, e});
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge core_clk);
			#1;
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_mismatch);
			if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask

	// free-running clock, 10 ns period
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// watchdog: the tests need well under a tenth of this span
	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		end_sim;
	end
	initial begin
		{rst, cal_upd_valid, playback_active, imp_valid, fault_clear} = 5'h10;
		{cal_upd_factor, target_mv10, supply_mv10, imp_measured} = 58'h0;
		{pwm_level, track_error, bemf_level_code} = 18'h0;
		cyc(6);
		rst = 1'b0;
		// reset values, read-only and unmapped places
		for (i = 0; i < 13; i = i + 1) rdc(ofs_t[103-8*i -: 8], rst_t[103-8*i -: 8]);
		chk({erm_q, loop_q, trk_q, acc_q, rs_q, amp_q, sgn_q, fac_q}, 23'h3c010d);
		$display("test reset done");
		// all ones, all zeros, then random bytes into every place
		for (k = 0; k < 5; k = k + 1) begin
			for (i = 0; i < 13; i = i + 1) begin
				a = ofs_t[103-8*i -: 8];
				rq = $random(seed);
				v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : rq[7:0];
				host.wr(a, v);
				rdc(a, v & msk_t[103-8*i -: 8]);
				if (a == 8'h13) v13 = v;
				if (a == 8'h14) v14 = v;
				if (a == 8'h0f) vf = v;
				if (a == 8'h10) vl = v;
				if (a == 8'h1c) vk = v;
			end
			chk({erm_q, loop_q, trk_q, acc_q, rs_q, amp_q}, {v13[5:4], v13[3] & ~v13[5], v13[2:0]});
			chk({sgn_q, kp_q}, {v14[4], vk});
			chk(fac_q, {vf, vl});
		end
		$display("test access done");
		rq = $random(seed);
		imp_measured = rq[9:0];
		imp_valid = 1'b1;
		cyc(1);
		imp_valid = 1'b0;
		rdc(8'h11, imp_measured[9:2]);
		rdc(8'h12, {6'h00, imp_measured[1:0]});
		$display("test impedance done");
		ef = f_fac(22000, 194);
		host.wr(8'h0f, ef[15:8]);
		host.wr(8'h10, ef[7:0]);
		// freeze; blocked in playback; allowed idle; allowed in playback without block
		for (k = 0; k < 4; k = k + 1) begin
			host.wr(8'h16, {k == 0, k == 1 || k == 2, 6'h00});
			playback_active = (k == 1 || k == 3);
			rq = $random(seed);
			cal_upd_factor = rq[15:0];
			cal_upd_valid = 1'b1;
			cyc(1);
			cal_upd_valid = 1'b0;
			cyc(3);
			if (k > 1) ef = cal_upd_factor;
			chk(fac_q, ef);
		end
		$display("test calibration done");
		host.wr(8'h13, 8'h9e);
		// clamp, brake, lock and back-emf limits against random inputs
		for (i = 0; i < 40; i = i + 1) begin
			r = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
			host.wr(8'h15, {4'h0, r[3:0]});
			host.wr(8'h14, {4'h0, r[7:4]});
			host.wr(8'h17, r[15:8]);
			{target_mv10, supply_mv10} = $random(seed);
			rq = $random(seed);
			{pwm_level, track_error, bemf_level_code} = rq[17:0];
			cyc(4);
			chk({clmp_q, lim_q}, f_lim(target_mv10, supply_mv10, r[3:0]));
			chk({brk_q, lck_q, bf_q}, {r[7:4] != 0 && pwm_level < r[7:4] * 17,
				track_error < 4 * r[15:10], r[9:8] != 0 && bemf_level_code < r[9:8]});
		end
		$display("test limits done");
		// faults latch until the host clears them when auto clear is off
		host.wr(8'h13, 8'h1e);
		host.wr(8'h17, 8'h03);
		{target_mv10, supply_mv10, bemf_level_code} = 34'h3fffc0000;
		cyc(4);
		{target_mv10, supply_mv10, bemf_level_code} = 34'h0000ffff3;
		cyc(4);
		chk({clmp_q, bf_q}, 2'b11);
		fault_clear = 1'b1;
		cyc(1);
		fault_clear = 1'b0;
		cyc(3);
		chk({clmp_q, bf_q}, 2'b00);
		$display("test fault latch done");
		end_sim;
	end
endmodule // hdc_config_bank_tb
`default_nettype wire
